// *** dv/cce_core_checker.sv ***
// Assertion checker bound to the processor core execution block.
`timescale 1ns/1ps
module cce_core_checker
  import cce_pkg::*;
(
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Watched outputs.
  input wire logic [CCE_PC_W-1:0] o_prog_addr,
  input wire logic [CCE_PC_W-1:0] o_window_addr,
  input wire logic o_dmem_rd,
  input wire logic [CCE_DATA_W-1:0] o_dmem_raddr,
  input wire logic o_dmem_wr,
  input wire logic [CCE_DATA_W-1:0] o_dmem_waddr,
  input wire logic o_irq_ack,
  input wire logic [7:0] o_irq_ack_id,
  input wire logic [CCE_LVL_W-1:0] o_cpu_level,
  input wire logic [CCE_DATA_W-1:0] o_core_control,
  input wire logic [CCE_PAGE_W-1:0] o_program_window_page
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  chk_fetch_start: assert property ($rose(i_rst_n) |-> o_prog_addr == CCE_PC_RESET)
    else $error("First fetch is not at the reset address.");
  chk_reset_state: assert property ($rose(i_rst_n) |-> o_cpu_level == 4'h0 && o_core_control == 16'h0000 && o_program_window_page == 8'h00)
    else $error("Reset state not clear.");
  chk_ack_pulse: assert property (o_irq_ack |=> !o_irq_ack)
    else $error("Acknowledge too long.");
  chk_stack_push: assert property (o_irq_ack |-> o_dmem_wr && $past(o_dmem_wr) && o_dmem_waddr == $past(o_dmem_waddr) + CCE_PTR_STEP)
    else $error("Entry did not push two words.");
  chk_irq_level: assert property (o_irq_ack && !o_irq_ack_id[7] |-> !o_cpu_level[3] && o_cpu_level != 4'h0)
    else $error("Interrupt taken at no level.");
  chk_trap_level: assert property (o_irq_ack && o_irq_ack_id[7] |-> o_cpu_level == CCE_LVL_TRAP && o_core_control[CCE_LVL3_BIT])
    else $error("Trap taken at wrong level.");
  chk_ctrl_bits: assert property (o_core_control[15:4] == 12'h000 && o_core_control[1:0] == 2'h0 && o_core_control[3] == o_cpu_level[3])
    else $error("Control word has stray bits.");
  chk_window_addr: assert property (o_window_addr == {1'b0, o_program_window_page, o_dmem_raddr[14:1]})
    else $error("Window address mismatch.");
  chk_window_gate: assert property (o_core_control[CCE_WIN_EN_BIT] && o_dmem_raddr[15] |-> !o_dmem_rd)
    else $error("Data memory read while the window serves it.");
  // Main scenarios reached.
  cover property (o_irq_ack && o_irq_ack_id[7]);
  cover property (o_irq_ack && !o_irq_ack_id[7]);
  cover property (o_core_control[CCE_WIN_EN_BIT] && o_dmem_raddr[15]);
endmodule // cce_core_checker

bind cce_core cce_core_checker i_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .o_prog_addr(o_prog_addr), .o_window_addr(o_window_addr), .o_dmem_rd(o_dmem_rd),
  .o_dmem_raddr(o_dmem_raddr), .o_dmem_wr(o_dmem_wr), .o_dmem_waddr(o_dmem_waddr),
  .o_irq_ack(o_irq_ack), .o_irq_ack_id(o_irq_ack_id), .o_cpu_level(o_cpu_level),
  .o_core_control(o_core_control), .o_program_window_page(o_program_window_page));

// *** dv/cce_core_tb.sv ***
// Self-checking testbench of the processor core execution block.
`timescale 1ns/1ps
module cce_core_tb;
  import cce_pkg::*;
  logic i_clock, i_rst_n, rd, wr, ack, rep;
  logic [CCE_PC_W-1:0] pa, wa;
  logic [CCE_INSTR_W-1:0] pi;
  logic [15:0] wd, ra, rdat, wad, wdat, ctl, a, b;
  logic [CCE_NUM_TRAP-1:0] trq;
  logic [CCE_NUM_IRQ-1:0] irq;
  logic [CCE_NUM_IRQ*CCE_PRIO_W-1:0] lvl;
  logic [7:0] aid, page;
  logic [3:0] lev;
  logic [31:0] p;
  logic [15:0] exp_a[$], exp_d[$];
  int err_count, n_tests, seed;

  // ==========================================================================
  // Design and memory model
  cce_core i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .o_prog_addr(pa), .i_prog_instr(pi),
    .o_window_addr(wa), .i_window_data(wd), .o_dmem_rd(rd), .o_dmem_raddr(ra),
    .i_dmem_rdata(rdat), .o_dmem_wr(wr), .o_dmem_waddr(wad), .o_dmem_wdata(wdat),
    .i_trap_req(trq), .i_irq_req(irq), .i_irq_level(lvl), .o_irq_ack(ack),
    .o_irq_ack_id(aid), .o_cpu_level(lev), .o_repeat_active(rep), .o_core_control(ctl),
    .o_program_window_page(page));
  cce_mem_model i_mem (.i_clock(i_clock), .i_prog_addr(pa), .o_prog_instr(pi),
    .i_window_addr(wa), .o_window_data(wd), .i_rd(rd), .i_raddr(ra), .o_rdata(rdat),
    .i_wr(wr), .i_waddr(wad), .i_wdata(wdat));

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Waits a bounded time for an acknowledge and checks its source code.
  task automatic wait_ack(input logic [7:0] id);
    for (int k = 0; k < 60; k++) begin
      @(posedge i_clock);
      #1;
      if (ack === 1'b1) break;
    end
    check("ack id", {7'h00, ack, aid}, {8'h01, id});
  endtask

  // Loads the program with random operands, resets the core and notes the expected stores.
  task automatic run_prog;
    logic [23:0] code [16];
    a = 16'($random(seed));
    b = 16'($random(seed)) | 16'h0001;
    p = a * b;
    code = '{{8'h12, a}, {8'h13, b}, 24'h242300, 24'hC40100, 24'h362300, 24'hC60102,
      24'hC70104, 24'h402300, 24'hC00106, 24'hC10108, 24'hD00005, 24'hE00004,
      24'hB88006, 24'hC8010A, 24'h500001, 24'hC2010C};
    i_mem.prog = '{default: 24'h000000};
    for (int k = 0; k < 16; k++) i_mem.prog[k] = code[k];
    exp_a = '{16'h0100, 16'h0102, 16'h0104, 16'h0106, 16'h0108, 16'h010A, 16'h010C, 16'h010C};
    exp_d = '{16'(a + b), p[15:0], p[31:16], a / b, a % b, 16'hE5A6, a, a};
    @(posedge i_clock);
    #1 i_rst_n = 1'b0;
    repeat (16) @(posedge i_clock);
    #1 i_rst_n = 1'b1;
    for (int k = 0; k < 200 && exp_a.size() != 0; k++) @(posedge i_clock);
    check("stores left", 16'(exp_a.size()), 16'h0000);
    check("window page", {8'h00, page}, 16'h0005);
  endtask

  // ==========================================================================
  // Clock, watchdog and store monitor
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  initial begin
    #100000;
    err_count++;
    $display("watchdog expired");
    end_sim();
  end

  // Compares each store with address bit 8 set to the oldest note in the queue.
  always @(posedge i_clock) begin
    if (i_rst_n === 1'b1 && wr === 1'b1 && wad[8] === 1'b1) begin
      if (exp_a.size() == 0) begin
        check("unexpected store", wad, 16'h0000);
      end else begin
        check("repeat flag", {15'h0, rep}, {15'h0, exp_a[0] == 16'h010C});
        check("store address", wad, exp_a.pop_front());
        check("store data", wdat, exp_d.pop_front());
      end
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h4fe75c76;
    err_count = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    trq = '0;
    irq = '0;
    lvl = '0;
    for (int it = 0; it < 2; it++) begin
      run_prog();
      #1 irq[0] = 1'b1;
      lvl[2:0] = 3'h3;
      wait_ack(8'h00);
      repeat (2) @(posedge i_clock);
      check("irq level", {12'h000, lev}, 16'h0003);
      #1 irq[0] = 1'b0;
      trq[6] = 1'b1;
      wait_ack(8'h86);
      trq[6] = 1'b0;
      repeat (2) @(posedge i_clock);
      check("trap level", {12'h000, lev}, 16'h0008);
      check("core control", ctl, 16'h000C);
      $display("test %0d done", it);
    end
    end_sim();
  end
endmodule // cce_core_tb

// *** dv/cce_mem_model.sv ***
// Program, window and data memory model facing the core.
`timescale 1ns/1ps
module cce_mem_model
  import cce_pkg::*;
(
  // Clock.
  input wire logic i_clock,
  // Program and window ports.
  input wire logic [CCE_PC_W-1:0] i_prog_addr,
  output logic [CCE_INSTR_W-1:0] o_prog_instr,
  input wire logic [CCE_PC_W-1:0] i_window_addr,
  output logic [CCE_DATA_W-1:0] o_window_data,
  // Data ports.
  input wire logic i_rd,
  input wire logic [CCE_DATA_W-1:0] i_raddr,
  output logic [CCE_DATA_W-1:0] o_rdata,
  input wire logic i_wr,
  input wire logic [CCE_DATA_W-1:0] i_waddr,
  input wire logic [CCE_DATA_W-1:0] i_wdata
);
  logic [CCE_INSTR_W-1:0] prog [64];
  logic [CCE_DATA_W-1:0] dmem [256];
  // Reads answer in the same cycle; space past the image holds no-ops.
  assign o_prog_instr = (i_prog_addr < 23'h000040) ? prog[i_prog_addr[5:0]] : 24'h000000;
  assign o_window_data = i_window_addr[15:0] ^ 16'hA5A5;
  // An unselected read bus shows a moving pattern, never stale data.
  assign o_rdata = i_rd ? dmem[i_raddr[8:1]] : ~i_raddr;
  // Writes land at the clock edge.
  always @(posedge i_clock) begin
    if (i_wr) begin
      dmem[i_waddr[8:1]] <= i_wdata;
    end
  end
endmodule // cce_mem_model

// *** logic/cce_core.sv ***
// Execution core: fetch, register array, ALU, multiplier, divider, repeat and traps.
`timescale 1ns/1ps

// What this block does
// - Works on 16-bit data and fetches 24-bit instructions with a fixed four-bit opcode field.
// - Program counter is 23 bits wide, reaching 8M instruction words.
// - Prefetch gives one cycle per instruction; flow changes, double move and divide take longer.
// - Repeat loops cost no overhead and an interrupt may break in anywhere.
// - Sixteen 16-bit working registers act as data or address.
// - The last working register is the stack pointer for calls and interrupts.
// - Upper 32 Kbytes of data space read program space at an 8-bit page.
// - One memory read, register read, memory write and fetch per cycle.
// - Inherent, relative, literal, direct and register direct or indirect addressing modes.
// - A 17x17 multiplier gives signed, unsigned, mixed 16x16 or 8x8 products.
// - Every multiply completes in one instruction cycle.
// - Non-restoring iterative divide of 32 or 16-bit by 16-bit, signed or unsigned.
// - Each divide takes 19 cycles and may be interrupted at any cycle.
// - Vectored exceptions: eight non-maskable traps and 118 interrupt sources.
// - Each interrupt source takes one of seven priority levels.
// - Divide leaves the quotient in register zero and remainder in register one.
// - The program window is active only while the enable control bit is set.
module cce_core
  import cce_pkg::*;
#(
  parameter int NUM_IRQ = CCE_NUM_IRQ,
  parameter int NUM_TRAP = CCE_NUM_TRAP
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Program memory fetch port.
  output logic [CCE_PC_W-1:0] o_prog_addr,
  input wire logic [CCE_INSTR_W-1:0] i_prog_instr,
  // Program window read port.
  output logic [CCE_PC_W-1:0] o_window_addr,
  input wire logic [CCE_DATA_W-1:0] i_window_data,
  // Data memory read and write ports.
  output logic o_dmem_rd,
  output logic [CCE_DATA_W-1:0] o_dmem_raddr,
  input wire logic [CCE_DATA_W-1:0] i_dmem_rdata,
  output logic o_dmem_wr,
  output logic [CCE_DATA_W-1:0] o_dmem_waddr,
  output logic [CCE_DATA_W-1:0] o_dmem_wdata,
  // Exception sources and acknowledge.
  input wire logic [NUM_TRAP-1:0] i_trap_req,
  input wire logic [NUM_IRQ-1:0] i_irq_req,
  input wire logic [NUM_IRQ*CCE_PRIO_W-1:0] i_irq_level,
  output logic o_irq_ack,
  output logic [7:0] o_irq_ack_id,
  // Status.
  output logic [CCE_LVL_W-1:0] o_cpu_level,
  output logic o_repeat_active,
  output logic [CCE_DATA_W-1:0] o_core_control,
  output logic [CCE_PAGE_W-1:0] o_program_window_page
);

  // ==========================================================================
  // State
  cce_state_t state_reg, state_next;
  logic [CCE_PC_W-1:0] pc_reg, ir_addr_reg, tgt_reg;
  logic [CCE_INSTR_W-1:0] ir_reg;
  logic ir_valid_reg, ra_reg, win_en_reg, rsign_reg, qneg_reg, rneg_reg;
  logic [13:0] rcount_reg;
  logic [CCE_LVL_W-1:0] cpu_level_reg;
  logic [CCE_PAGE_W-1:0] program_window_page_reg;
  logic [CCE_DATA_W-1:0] dvs_reg;
  logic [4:0] div_cnt_reg;
  cce_stack_hi_t stack_hi_reg, pop_hi;
  logic ack_reg;
  logic [7:0] ack_id_reg;
  logic [CCE_DATA_W-1:0] wreg [CCE_NUM_W];

  // ==========================================================================
  // Instruction fields and operands
  wire [3:0] op = ir_reg[23:20];
  wire [3:0] f_wd = ir_reg[19:16];
  wire [3:0] f_ws = ir_reg[15:12];
  wire [3:0] f_wt = ir_reg[11:8];
  wire [2:0] f_tm = ir_reg[7:5];
  wire f_dind = ir_reg[4];
  wire [3:0] f_fn = ir_reg[3:0];
  wire [15:0] f_lit = ir_reg[15:0];
  wire [15:0] ws_val = wreg[f_ws];
  wire [15:0] wt_val = wreg[f_wt];
  wire [15:0] wd_val = wreg[f_wd];
  wire [15:0] sp_val = wreg[CCE_SP_IDX];
  wire [3:0] wd_even = {f_wd[3:1], 1'b0};
  wire [3:0] wd_odd = {f_wd[3:1], 1'b1};

  // Register indirect modes: pre-modified address and updated pointer.
  // addressing mode decode
  wire t_pre_inc = (f_tm == CCE_AM_PREINC);
  wire t_pre_dec = (f_tm == CCE_AM_PREDEC);
  wire [15:0] t_pre = t_pre_inc ? wt_val + CCE_PTR_STEP :
                      t_pre_dec ? wt_val - CCE_PTR_STEP : wt_val;
  wire [15:0] t_post = (f_tm == CCE_AM_POSTINC) ? wt_val + CCE_PTR_STEP :
                       (f_tm == CCE_AM_POSTDEC) ? wt_val - CCE_PTR_STEP : t_pre;
  wire t_mem = (f_tm != CCE_AM_DIR) && (f_tm != CCE_AM_LIT);
  wire t_upd = t_mem && (f_tm != CCE_AM_IND);

  // Read data comes from program space when the window is enabled and hit.
  logic [15:0] rd_addr;
  wire win_hit = win_en_reg && rd_addr[15];
  wire [15:0] rd_data = win_hit ? i_window_data : i_dmem_rdata;

  // Second operand and ALU result.
  wire [15:0] alu_b = (f_tm == CCE_AM_DIR) ? wt_val :
                      (f_tm == CCE_AM_LIT) ? {12'h000, f_wt} : rd_data;
  logic [15:0] alu_res;
  always_comb begin
    case (f_fn)
      CCE_FN_ADD: alu_res = ws_val + alu_b;
      CCE_FN_SUB: alu_res = ws_val - alu_b;
      CCE_FN_AND: alu_res = ws_val & alu_b;
      CCE_FN_IOR: alu_res = ws_val | alu_b;
      CCE_FN_XOR: alu_res = ws_val ^ alu_b;
      default: alu_res = alu_b;
    endcase
  end

  // Operands widened to 17 bits so one signed multiplier serves every mode.
  // signedness and size select
  wire m_byte = f_fn[CCE_MUL_BYTE];
  wire m_sa = f_fn[CCE_MUL_SA] & (m_byte ? ws_val[7] : ws_val[15]);
  wire m_sb = f_fn[CCE_MUL_SB] & (m_byte ? wt_val[7] : wt_val[15]);
  wire [16:0] m_a = m_byte ? {{9{m_sa}}, ws_val[7:0]} : {m_sa, ws_val};
  wire [16:0] m_b = m_byte ? {{9{m_sb}}, wt_val[7:0]} : {m_sb, wt_val};
  wire signed [33:0] m_prod = $signed(m_a) * $signed(m_b);

  // Divider operands, magnitudes and one non-restoring step.
  wire d_sgn = f_fn[CCE_DIV_SIGNED];
  wire [31:0] d_dvd = f_fn[CCE_DIV_LONG] ? {wreg[{f_ws[3:1], 1'b1}], wreg[{f_ws[3:1], 1'b0}]} :
                      {{16{d_sgn & ws_val[15]}}, ws_val};
  wire d_dvd_neg = d_sgn & d_dvd[31];
  wire d_dvs_neg = d_sgn & wt_val[15];
  wire [31:0] d_dvd_mag = d_dvd_neg ? 32'h0 - d_dvd : d_dvd;
  wire [15:0] d_q = wreg[CCE_QUO_IDX];
  wire [15:0] d_r = wreg[CCE_REM_IDX];
  wire [17:0] d_sh = {rsign_reg, d_r, d_q[15]};
  wire [17:0] d_step = rsign_reg ? d_sh + {2'b00, dvs_reg} : d_sh - {2'b00, dvs_reg};
  logic [15:0] d_q_next, d_r_next;
  always_comb begin
    d_q_next = d_q;
    d_r_next = d_r;
    if (div_cnt_reg == CCE_DIV_START) begin
      d_q_next = d_dvd_mag[15:0];
      d_r_next = d_dvd_mag[31:16];
    end else if (div_cnt_reg <= CCE_DIV_ITER_LAST) begin
      d_q_next = {d_q[14:0], ~d_step[17]};
      d_r_next = d_step[15:0];
    end else if (div_cnt_reg == CCE_DIV_FIX) begin
      d_r_next = rsign_reg ? d_r + dvs_reg : d_r;
    end else begin
      d_q_next = qneg_reg ? 16'h0000 - d_q : d_q;
      d_r_next = rneg_reg ? 16'h0000 - d_r : d_r;
    end
  end

  // ==========================================================================
  // Exception selection
  // Highest priority source wins; ties go to the lowest index.
  logic [CCE_PRIO_W-1:0] ch_lvl [NUM_IRQ+1];
  logic [6:0] ch_id [NUM_IRQ+1];
  logic [2:0] tr_id [NUM_TRAP+1];
  assign ch_lvl[0] = '0;
  assign ch_id[0] = '0;
  assign tr_id[0] = '0;
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    wire [CCE_PRIO_W-1:0] lvl = i_irq_level[i*CCE_PRIO_W +: CCE_PRIO_W];
    wire win = i_irq_req[i] && (lvl > ch_lvl[i]);
    assign ch_lvl[i+1] = win ? lvl : ch_lvl[i];
    assign ch_id[i+1] = win ? 7'(i) : ch_id[i];
  end
  for (genvar k = 0; k < NUM_TRAP; k++) begin : g_trap
    assign tr_id[k+1] = i_trap_req[NUM_TRAP-1-k] ? 3'(NUM_TRAP-1-k) : tr_id[k];
  end

  // Traps ignore the level mask unless a trap is already in service.
  // vectored trap and interrupt take
  wire take_trap = (|i_trap_req) && (cpu_level_reg < CCE_LVL_TRAP);
  wire take_irq = {1'b0, ch_lvl[NUM_IRQ]} > cpu_level_reg;
  wire take = (state_reg == CCE_ST_RUN) && (take_trap || take_irq);
  wire [CCE_LVL_W-1:0] take_lvl = take_trap ? CCE_LVL_TRAP : {1'b0, ch_lvl[NUM_IRQ]};
  wire [CCE_PC_W-1:0] take_vec = take_trap ? CCE_VEC_TRAP_BASE + {19'h0, tr_id[NUM_TRAP], 1'b0} :
                                 CCE_VEC_IRQ_BASE + {15'h0, ch_id[NUM_IRQ], 1'b0};
  wire [CCE_PC_W-1:0] ret_addr = (take && ir_valid_reg) ? ir_addr_reg : pc_reg;
  assign pop_hi = cce_stack_hi_t'(rd_data);

  // ==========================================================================
  // Control decode
  logic wa_en, wb_en, rd_en, wr_en, done, jump;
  logic [3:0] wa_idx, wb_idx;
  logic [15:0] wa_dat, wb_dat, wr_addr, wr_dat;
  logic [CCE_PC_W-1:0] jump_tgt;
  always_comb begin
    state_next = state_reg;
    wa_en = 1'b0;
    wa_idx = f_wd;
    wa_dat = alu_res;
    wb_en = 1'b0;
    wb_idx = f_wt;
    wb_dat = t_post;
    rd_en = 1'b0;
    rd_addr = t_pre;
    wr_en = 1'b0;
    wr_addr = wd_val;
    wr_dat = alu_res;
    done = 1'b0;
    jump = 1'b0;
    jump_tgt = tgt_reg;
    case (state_reg)
      CCE_ST_RUN: begin
        if (take || (ir_valid_reg && op == CCE_OP_CALL)) begin
          // low return word pushed at the stack pointer
          wr_en = 1'b1;
          wr_addr = sp_val;
          wr_dat = ret_addr[15:0];
          wb_en = 1'b1;
          wb_idx = CCE_SP_IDX;
          wb_dat = sp_val + CCE_PTR_STEP;
          state_next = CCE_ST_PUSH;
        end else if (ir_valid_reg) begin
          case (op)
            CCE_OP_MOVL: begin
              wa_en = 1'b1;
              wa_dat = f_lit;
              done = 1'b1;
            end
            CCE_OP_ALU: begin
              // read, register, write in one cycle
              rd_en = t_mem;
              wb_en = t_upd;
              wr_en = f_dind;
              wa_en = !f_dind;
              done = 1'b1;
            end
            CCE_OP_MUL: begin
              wa_en = 1'b1;
              wa_idx = wd_even;
              wa_dat = m_prod[15:0];
              wb_en = 1'b1;
              wb_idx = wd_odd;
              wb_dat = m_prod[31:16];
              done = 1'b1;
            end
            CCE_OP_DIV: begin
              wa_en = 1'b1;
              wa_idx = CCE_QUO_IDX;
              wa_dat = d_q_next;
              wb_en = 1'b1;
              wb_idx = CCE_REM_IDX;
              wb_dat = d_r_next;
              done = (div_cnt_reg == CCE_DIV_LAST);
            end
            CCE_OP_BRA: begin
              jump = 1'b1;
              jump_tgt = pc_reg + {{7{f_lit[15]}}, f_lit};
            end
            CCE_OP_RETURN, CCE_OP_RETFIE: begin
              rd_en = 1'b1;
              rd_addr = sp_val - CCE_PTR_STEP;
              wb_en = 1'b1;
              wb_idx = CCE_SP_IDX;
              wb_dat = sp_val - CCE_PTR_STEP;
              state_next = CCE_ST_POP;
            end
            CCE_OP_MOVD: begin
              rd_en = 1'b1;
              rd_addr = ws_val;
              wa_en = 1'b1;
              wa_idx = wd_even;
              wa_dat = rd_data;
              state_next = CCE_ST_MOVD;
            end
            CCE_OP_LDM: begin
              rd_en = 1'b1;
              rd_addr = f_lit;
              wa_en = 1'b1;
              wa_dat = rd_data;
              done = 1'b1;
            end
            CCE_OP_STM: begin
              wr_en = 1'b1;
              wr_addr = f_lit;
              wr_dat = wd_val;
              done = 1'b1;
            end
            default: done = 1'b1;
          endcase
        end
      end
      CCE_ST_PUSH: begin
        wr_en = 1'b1;
        wr_addr = sp_val;
        wr_dat = stack_hi_reg;
        wb_en = 1'b1;
        wb_idx = CCE_SP_IDX;
        wb_dat = sp_val + CCE_PTR_STEP;
        jump = 1'b1;
        state_next = CCE_ST_RUN;
      end
      CCE_ST_POP: begin
        rd_en = 1'b1;
        rd_addr = sp_val - CCE_PTR_STEP;
        wb_en = 1'b1;
        wb_idx = CCE_SP_IDX;
        wb_dat = sp_val - CCE_PTR_STEP;
        jump = 1'b1;
        jump_tgt = {stack_hi_reg.pc_hi, rd_data};
        state_next = CCE_ST_RUN;
      end
      CCE_ST_MOVD: begin
        // second word of the double move
        rd_en = 1'b1;
        rd_addr = ws_val + CCE_PTR_STEP;
        wa_en = 1'b1;
        wa_idx = wd_odd;
        wa_dat = rd_data;
        done = 1'b1;
        state_next = CCE_ST_RUN;
      end
      default: state_next = CCE_ST_RUN;
    endcase
  end

  // Repeat holds the instruction in place while the count runs down.
  // repeat hold
  wire rep_hold = done && ra_reg && (rcount_reg != 14'h0000) && (op != CCE_OP_REPEAT);
  wire fetch = (state_reg == CCE_ST_RUN && !take && !ir_valid_reg) || (done && !rep_hold);

  // ==========================================================================
  // Working registers, one write port each side; port A wins a clash.
  // sixteen general registers
  for (genvar w = 0; w < CCE_NUM_W; w++) begin : g_wreg
    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        wreg[w] <= '0;
      end else if (wa_en && wa_idx == 4'(w)) begin
        wreg[w] <= wa_dat;
      end else if (wb_en && wb_idx == 4'(w)) begin
        wreg[w] <= wb_dat;
      end
    end
  end

  // Fetch, flow, repeat, level and divider state.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_reg <= CCE_ST_RUN;
      pc_reg <= CCE_PC_RESET;
      ir_reg <= '0;
      ir_addr_reg <= CCE_PC_RESET;
      ir_valid_reg <= 1'b0;
      tgt_reg <= CCE_PC_RESET;
      stack_hi_reg <= '0;
      ra_reg <= 1'b0;
      rcount_reg <= '0;
      cpu_level_reg <= '0;
      win_en_reg <= 1'b0;
      program_window_page_reg <= '0;
      div_cnt_reg <= CCE_DIV_START;
      dvs_reg <= '0;
      rsign_reg <= 1'b0;
      qneg_reg <= 1'b0;
      rneg_reg <= 1'b0;
      ack_reg <= 1'b0;
      ack_id_reg <= '0;
    end else begin
      state_reg <= state_next;
      ack_reg <= take;
      if (take) begin
        ack_id_reg <= take_trap ? {5'h10, tr_id[NUM_TRAP]} : {1'b0, ch_id[NUM_IRQ]};
        tgt_reg <= take_vec;
        stack_hi_reg <= '{pad: '0, ra: ra_reg, lvl: cpu_level_reg, pc_hi: ret_addr[22:16]};
        cpu_level_reg <= take_lvl;
        ra_reg <= 1'b0;
      end else if (state_reg == CCE_ST_RUN && ir_valid_reg && op == CCE_OP_CALL) begin
        tgt_reg <= {3'b000, f_wd, f_lit};
        stack_hi_reg <= '{pad: '0, ra: 1'b0, lvl: cpu_level_reg, pc_hi: pc_reg[22:16]};
      end else if (state_next == CCE_ST_POP) begin
        stack_hi_reg <= pop_hi;
      end
      if (state_reg == CCE_ST_POP && op == CCE_OP_RETFIE) begin
        cpu_level_reg <= stack_hi_reg.lvl;
        ra_reg <= stack_hi_reg.ra;
      end
      if (jump) begin
        pc_reg <= jump_tgt;
        ir_valid_reg <= 1'b0;
      end else if (fetch) begin
        ir_reg <= i_prog_instr;
        ir_addr_reg <= pc_reg;
        pc_reg <= pc_reg + 23'h000001;
        ir_valid_reg <= 1'b1;
      end
      if (rep_hold) begin
        rcount_reg <= rcount_reg - 14'h0001;
      end else if (done && op == CCE_OP_REPEAT) begin
        rcount_reg <= f_lit[13:0];
        ra_reg <= 1'b1;
      end else if (done && ra_reg) begin
        ra_reg <= 1'b0;
      end
      if (done && op == CCE_OP_PAGE) begin
        program_window_page_reg <= f_lit[CCE_PAGE_W-1:0];
      end
      if (done && op == CCE_OP_CORE) begin
        win_en_reg <= f_lit[CCE_WIN_EN_BIT];
      end
      if (state_reg == CCE_ST_RUN && !take && ir_valid_reg && op == CCE_OP_DIV) begin
        div_cnt_reg <= done ? CCE_DIV_START : div_cnt_reg + 5'h01;
        if (div_cnt_reg == CCE_DIV_START) begin
          dvs_reg <= d_dvs_neg ? 16'h0000 - wt_val : wt_val;
          qneg_reg <= d_dvd_neg ^ d_dvs_neg;
          rneg_reg <= d_dvd_neg;
          rsign_reg <= 1'b0;
        end else if (div_cnt_reg <= CCE_DIV_ITER_LAST) begin
          rsign_reg <= d_step[17];
        end
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign o_prog_addr = pc_reg;
  assign o_window_addr = {1'b0, program_window_page_reg, rd_addr[14:1]};
  assign o_dmem_rd = rd_en && !win_hit;
  assign o_dmem_raddr = rd_addr;
  assign o_dmem_wr = wr_en;
  assign o_dmem_waddr = wr_addr;
  assign o_dmem_wdata = wr_dat;
  assign o_irq_ack = ack_reg;
  assign o_irq_ack_id = ack_id_reg;
  assign o_cpu_level = cpu_level_reg;
  assign o_repeat_active = ra_reg;
  assign o_core_control = (16'(win_en_reg) << CCE_WIN_EN_BIT) |
                          (16'(cpu_level_reg[3]) << CCE_LVL3_BIT);
  assign o_program_window_page = program_window_page_reg;

endmodule // cce_core

// *** logic/cce_pkg.sv ***
// Shared constants, encodings and types of the processor core execution block.
package cce_pkg;

  // ==========================================================================
  // Widths and counts
  localparam int CCE_DATA_W = 16;
  localparam int CCE_INSTR_W = 24;
  localparam int CCE_PC_W = 23;
  localparam int CCE_NUM_W = 16;
  localparam int CCE_NUM_TRAP = 8;
  localparam int CCE_NUM_IRQ = 118;
  localparam int CCE_PRIO_W = 3;
  localparam int CCE_LVL_W = 4;
  localparam int CCE_PAGE_W = 8;
  localparam int CCE_WIDX_W = 4;

  // ==========================================================================
  // Opcodes in the top four instruction bits
  localparam logic [3:0] CCE_OP_NOP = 4'h0;
  localparam logic [3:0] CCE_OP_MOVL = 4'h1;
  localparam logic [3:0] CCE_OP_ALU = 4'h2;
  localparam logic [3:0] CCE_OP_MUL = 4'h3;
  localparam logic [3:0] CCE_OP_DIV = 4'h4;
  localparam logic [3:0] CCE_OP_REPEAT = 4'h5;
  localparam logic [3:0] CCE_OP_BRA = 4'h6;
  localparam logic [3:0] CCE_OP_CALL = 4'h7;
  localparam logic [3:0] CCE_OP_RETURN = 4'h8;
  localparam logic [3:0] CCE_OP_RETFIE = 4'h9;
  localparam logic [3:0] CCE_OP_MOVD = 4'hA;
  localparam logic [3:0] CCE_OP_LDM = 4'hB;
  localparam logic [3:0] CCE_OP_STM = 4'hC;
  localparam logic [3:0] CCE_OP_PAGE = 4'hD;
  localparam logic [3:0] CCE_OP_CORE = 4'hE;

  // ALU functions in the low four bits.
  localparam logic [3:0] CCE_FN_ADD = 4'h0;
  localparam logic [3:0] CCE_FN_SUB = 4'h1;
  localparam logic [3:0] CCE_FN_AND = 4'h2;
  localparam logic [3:0] CCE_FN_IOR = 4'h3;
  localparam logic [3:0] CCE_FN_XOR = 4'h4;

  // Flag bits of multiply and divide in the low four bits.
  localparam int CCE_MUL_SA = 0;
  localparam int CCE_MUL_SB = 1;
  localparam int CCE_MUL_BYTE = 2;
  localparam int CCE_DIV_SIGNED = 0;
  localparam int CCE_DIV_LONG = 1;

  // Source addressing modes of the second operand.
  localparam logic [2:0] CCE_AM_DIR = 3'h0;
  localparam logic [2:0] CCE_AM_IND = 3'h1;
  localparam logic [2:0] CCE_AM_POSTINC = 3'h2;
  localparam logic [2:0] CCE_AM_POSTDEC = 3'h3;
  localparam logic [2:0] CCE_AM_PREINC = 3'h4;
  localparam logic [2:0] CCE_AM_PREDEC = 3'h5;
  localparam logic [2:0] CCE_AM_LIT = 3'h6;

  // ==========================================================================
  // Fixed registers, control bits and timing
  localparam logic [3:0] CCE_SP_IDX = 4'hF;
  localparam logic [3:0] CCE_QUO_IDX = 4'h0;
  localparam logic [3:0] CCE_REM_IDX = 4'h1;
  localparam int CCE_WIN_EN_BIT = 2;
  localparam int CCE_LVL3_BIT = 3;
  localparam logic [15:0] CCE_PTR_STEP = 16'h0002;
  localparam logic [4:0] CCE_DIV_START = 5'h00;
  localparam logic [4:0] CCE_DIV_ITER_LAST = 5'h10;
  localparam logic [4:0] CCE_DIV_FIX = 5'h11;
  localparam logic [4:0] CCE_DIV_LAST = 5'h12;
  localparam logic [3:0] CCE_LVL_TRAP = 4'h8;
  localparam logic [22:0] CCE_VEC_TRAP_BASE = 23'h000004;
  localparam logic [22:0] CCE_VEC_IRQ_BASE = 23'h000014;
  localparam logic [22:0] CCE_PC_RESET = 23'h000000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {CCE_ST_RUN, CCE_ST_PUSH, CCE_ST_POP, CCE_ST_MOVD} cce_state_t;

  // Upper stacked word: repeat flag, saved level and upper return address.
  typedef struct packed {
    logic [3:0] pad;
    logic ra;
    logic [3:0] lvl;
    logic [6:0] pc_hi;
  } cce_stack_hi_t;

endpackage
